// >>> core/boundary_cell.sv
// Purpose: One boundary scan cell, pin variant or macrocell variant.
// Assumes: Strobes are one-cycle pulses from the test port controller.
// Notes: The macrocell variant only observes; it has no update stage.
`timescale 1ns/1ps
module boundary_cell
   import jtag_isp_pkg::*;
#(
   parameter bit IS_PIN = 1'b1
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic clr_i,
   input wire logic cap_en_i,
   input wire logic shift_en_i,
   input wire logic upd_en_i,
   input wire logic scan_i,
   input wire logic pin_in_i,
   input wire logic core_out_i,
   input wire logic core_oe_i,
   output logic scan_o,
   output logic upd_out_o,
   output logic upd_oe_o
);
   typedef struct packed {
      logic [2:0] cap;
      logic [1:0] upd;
   } cell_s;

   cell_s s_r;
   cell_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (clr_i) begin
         s_nxt = '0;
      end else if (cap_en_i) begin
         if (IS_PIN) begin
            s_nxt.cap = {pin_in_i, core_out_i, core_oe_i};
         end else begin
            s_nxt.cap = {core_out_i, 2'b00};
         end
      end else if (shift_en_i) begin
         if (IS_PIN) begin
            s_nxt.cap = {scan_i, s_r.cap[2:1]};
         end else begin
            s_nxt.cap[2] = scan_i;
         end
      end else if (upd_en_i && IS_PIN) begin
         s_nxt.upd = {s_r.cap[CB_OUT], s_r.cap[CB_OE]};
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign scan_o = IS_PIN ? s_r.cap[0] : s_r.cap[2];
   assign upd_out_o = s_r.upd[UB_OUT];
   assign upd_oe_o = s_r.upd[UB_OE];
endmodule : boundary_cell

// >>> core/jtag_boundary_scan_isp_port.sv
// Purpose: Test access port, boundary chain, pin release and power-up reset.
// Assumes: Test pins are sampled by the core clock, at least 8x faster.
// Notes: Port controller actions lag their test clock edge by three core clock cycles; boundary cell actions lag by one more.
`timescale 1ns/1ps
// How it works
// - Port controller resets at power-up; there is no test reset pin.
// - Five instructions: sample/preload, extest, bypass, idcode, highz.
// - Every dedicated input and every I/O pin owns a boundary cell.
// - Cells form one serial chain from TDI to TDO through captures.
// - A cell holds up to three capture stages and two update stages.
// - Two cell variants exist: pin cells and macrocell cells.
// - Captures sample live signals, shift serially, and load updates.
// - Capture, shift and update strobes come from the port controller.
// - With test access disabled the four test pins act as user I/O.
// - Programming read requests arrive on their own inputs, not over the four test pins.
// - Power-up initialises registers; outputs follow buffer polarity.
// - Power-up reset hysteresis is selectable as small or large.
// - Blown security fuse refuses verify reads; signature stays readable.
module jtag_boundary_scan_isp_port
   import jtag_isp_pkg::*;
#(
   parameter int NIO = NUM_IO_PINS,
   parameter int NIN = NUM_IN_PINS,
   parameter int NMC = NUM_MC,
   parameter logic [NIO+NIN-1:0] OUT_POL = '0,
   parameter bit HYST_LARGE = 1'b0,
   parameter int TD_CYC = POR_TD_CYC,
   parameter int DROP_CYC = HYST_DROP_CYC,
   // Arbitrary identification value; bit 0 is one as the standard asks.
   parameter logic [ID_W-1:0] IDCODE = 32'h0ABC_0001
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic jtag_en_i,
   input wire logic vdd_ok_i,
   input wire logic fuse_blown_i,
   input wire logic isp_rd_req_i,
   input wire logic isp_rd_sig_i,
   input wire logic [3:0] jtag_pin_i,
   input wire logic [3:0] user_jtag_out_i,
   input wire logic [3:0] user_jtag_oe_i,
   input wire logic [NIO+NIN-1:0] pin_in_i,
   input wire logic [NIO+NIN-1:0] core_out_i,
   input wire logic [NIO+NIN-1:0] core_oe_i,
   input wire logic [NMC-1:0] mc_out_i,
   output logic [3:0] jtag_pin_o,
   output logic [3:0] jtag_pin_oe_o,
   output logic [3:0] user_jtag_in_o,
   output logic [NIO+NIN-1:0] pin_out_o,
   output logic [NIO+NIN-1:0] pin_oe_o,
   output logic [NIO+NIN-1:0] core_in_o,
   output logic isp_rd_ok_o,
   output logic isp_rd_refused_o,
   output logic por_busy_o
);
   localparam int NPIN = NIO + NIN;
   localparam int NCELL = NPIN + NMC;

   typedef struct packed {
      tap_state_e st;
      logic [3:0] jp_s1;
      logic [3:0] jp_s2;
      logic tck_q;
      logic tdi_q;
      logic [NPIN-1:0] pin_s1;
      logic [NPIN-1:0] pin_s2;
      logic vdd_s1;
      logic vdd_s2;
      logic por_busy;
      logic [CNT_W-1:0] por_cnt;
      logic [CNT_W-1:0] drop_cnt;
      logic [IR_W-1:0] ir;
      logic [IR_W-1:0] ir_sh;
      logic byp;
      logic [ID_W-1:0] id_sh;
      logic tdo;
      logic tdo_oe;
      logic cap_en;
      logic sh_en;
      logic upd_en;
      logic [NPIN-1:0] pin_out;
      logic [NPIN-1:0] pin_oe;
      logic [3:0] jp_out;
      logic [3:0] jp_oe;
      logic rd_ok;
      logic rd_ref;
   } port_s;

   port_s s_r;
   port_s s_nxt;
   logic [NCELL:0] chain;
   logic [NPIN-1:0] upd_out;
   logic [NPIN-1:0] upd_oe;
   logic tck_rise;
   logic tck_fall;
   logic tms;
   logic tdi;
   logic bnd_sel;
   logic extest;

   function automatic tap_state_e tap_next(input tap_state_e st,
                                           input logic m);
      case (st)
         TAP_TLR: tap_next = m ? TAP_TLR : TAP_RTI;
         TAP_RTI: tap_next = m ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: tap_next = m ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_IR: tap_next = m ? TAP_TLR : TAP_CAP_IR;
         TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: tap_next = m ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
         default: tap_next = TAP_TLR;
      endcase
   endfunction : tap_next

   // Edges are found on the second synchroniser stage only.
   assign tck_rise = s_r.jp_s2[JP_TCK] & ~s_r.tck_q;
   assign tck_fall = ~s_r.jp_s2[JP_TCK] & s_r.tck_q;
   assign tms = s_r.jp_s2[JP_TMS];
   assign tdi = s_r.jp_s2[JP_TDI];
   assign extest = (s_r.ir == IR_EXTEST);
   assign bnd_sel = extest || (s_r.ir == IR_SAMPLE);
   assign chain[0] = s_r.tdi_q;

   genvar g;
   generate
      for (g = 0; g < NCELL; g++) begin : g_cell
         if (g < NPIN) begin : g_pin
            boundary_cell #(.IS_PIN(1'b1)) u_cell (
               .core_clk_i(core_clk_i),
               .sys_rst_i(sys_rst_i),
               .clr_i(s_r.por_busy),
               .cap_en_i(s_r.cap_en),
               .shift_en_i(s_r.sh_en),
               .upd_en_i(s_r.upd_en),
               .scan_i(chain[g]),
               .pin_in_i(s_r.pin_s2[g]),
               .core_out_i(core_out_i[g]),
               .core_oe_i(core_oe_i[g]),
               .scan_o(chain[g+1]),
               .upd_out_o(upd_out[g]),
               .upd_oe_o(upd_oe[g])
            );
         end else begin : g_mc
            boundary_cell #(.IS_PIN(1'b0)) u_cell (
               .core_clk_i(core_clk_i),
               .sys_rst_i(sys_rst_i),
               .clr_i(s_r.por_busy),
               .cap_en_i(s_r.cap_en),
               .shift_en_i(s_r.sh_en),
               .upd_en_i(s_r.upd_en),
               .scan_i(chain[g]),
               .pin_in_i(1'b0),
               .core_out_i(mc_out_i[g-NPIN]),
               .core_oe_i(1'b0),
               .scan_o(chain[g+1]),
               .upd_out_o(),
               .upd_oe_o()
            );
         end
      end
   endgenerate

   always_comb begin
      s_nxt = s_r;
      s_nxt.jp_s1 = jtag_pin_i;
      s_nxt.jp_s2 = s_r.jp_s1;
      s_nxt.tck_q = s_r.jp_s2[JP_TCK];
      s_nxt.pin_s1 = pin_in_i;
      s_nxt.pin_s2 = s_r.pin_s1;
      s_nxt.vdd_s1 = vdd_ok_i;
      s_nxt.vdd_s2 = s_r.vdd_s1;
      s_nxt.cap_en = 1'b0;
      s_nxt.sh_en = 1'b0;
      s_nxt.upd_en = 1'b0;
      s_nxt.rd_ok = 1'b0;
      s_nxt.rd_ref = 1'b0;
      // Large hysteresis rides out short supply dips; small re-arms at once.
      if (!s_r.vdd_s2) begin
         if (!HYST_LARGE || s_r.drop_cnt == CNT_W'(DROP_CYC - 1)) begin
            s_nxt.por_busy = 1'b1;
            s_nxt.por_cnt = '0;
         end else begin
            s_nxt.drop_cnt = s_r.drop_cnt + 1'b1;
         end
      end else begin
         s_nxt.drop_cnt = '0;
         if (s_r.por_busy) begin
            if (s_r.por_cnt == CNT_W'(TD_CYC - 1)) begin
               s_nxt.por_busy = 1'b0;
            end else begin
               s_nxt.por_cnt = s_r.por_cnt + 1'b1;
            end
         end
      end
      if (s_r.por_busy || !jtag_en_i) begin
         s_nxt.st = TAP_TLR;
         s_nxt.ir = IR_IDCODE;
         s_nxt.tdo_oe = 1'b0;
      end else if (tck_rise) begin
         case (s_r.st)
            TAP_TLR: s_nxt.ir = IR_IDCODE;
            TAP_CAP_DR: begin
               s_nxt.byp = 1'b0;
               s_nxt.id_sh = IDCODE;
               s_nxt.cap_en = bnd_sel;
            end
            TAP_SH_DR: begin
               s_nxt.byp = tdi;
               s_nxt.id_sh = {tdi, s_r.id_sh[ID_W-1:1]};
               s_nxt.sh_en = bnd_sel;
            end
            TAP_UPD_DR: s_nxt.upd_en = bnd_sel;
            TAP_CAP_IR: s_nxt.ir_sh = IR_CAPT;
            TAP_SH_IR: s_nxt.ir_sh = {tdi, s_r.ir_sh[IR_W-1:1]};
            TAP_UPD_IR: s_nxt.ir = s_r.ir_sh;
            default: ;
         endcase
         s_nxt.tdi_q = tdi;
         s_nxt.st = tap_next(s_r.st, tms);
      end else if (tck_fall) begin
         s_nxt.tdo_oe = (s_r.st == TAP_SH_DR) || (s_r.st == TAP_SH_IR);
         if (s_r.st == TAP_SH_IR) begin
            s_nxt.tdo = s_r.ir_sh[0];
         end else if (bnd_sel) begin
            s_nxt.tdo = chain[NCELL];
         end else if (s_r.ir == IR_IDCODE) begin
            s_nxt.tdo = s_r.id_sh[0];
         end else begin
            s_nxt.tdo = s_r.byp;
         end
      end
      for (int i = 0; i < NPIN; i++) begin
         if (s_r.por_busy) begin
            s_nxt.pin_out[i] = OUT_POL[i];
            s_nxt.pin_oe[i] = 1'b0;
         end else begin
            s_nxt.pin_out[i] = extest ? upd_out[i] :
                               core_out_i[i] ^ OUT_POL[i];
            s_nxt.pin_oe[i] = (i < NIO) && (s_r.ir != IR_HIGHZ) &&
                              (extest ? upd_oe[i] : core_oe_i[i]);
         end
      end
      if (jtag_en_i) begin
         s_nxt.jp_out = '0;
         s_nxt.jp_oe = '0;
         s_nxt.jp_out[JP_TDO] = s_nxt.tdo;
         s_nxt.jp_oe[JP_TDO] = s_nxt.tdo_oe;
      end else begin
         s_nxt.jp_out = user_jtag_out_i;
         s_nxt.jp_oe = user_jtag_oe_i;
      end
      // The signature stays readable; pattern verify needs an intact fuse.
      if (isp_rd_req_i) begin
         if (isp_rd_sig_i || !fuse_blown_i) begin
            s_nxt.rd_ok = 1'b1;
         end else begin
            s_nxt.rd_ref = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_r <= '0;
         s_r.ir <= IR_IDCODE;
         s_r.por_busy <= 1'b1;
         s_r.pin_out <= OUT_POL;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign jtag_pin_o = s_r.jp_out;
   assign jtag_pin_oe_o = s_r.jp_oe;
   assign user_jtag_in_o = s_r.jp_s2;
   assign pin_out_o = s_r.pin_out;
   assign pin_oe_o = s_r.pin_oe;
   assign core_in_o = s_r.pin_s2;
   assign isp_rd_ok_o = s_r.rd_ok;
   assign isp_rd_refused_o = s_r.rd_ref;
   assign por_busy_o = s_r.por_busy;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   chk_por_holds_tlr: assert property (
      s_r.por_busy |=> s_r.st == TAP_TLR)
      else $error("controller left reset state during power-up reset");
   chk_tlr_loads_id: assert property (
      (s_r.st == TAP_TLR && tck_rise) |=> s_r.ir == IR_IDCODE)
      else $error("reset state did not select identification");
   chk_ir_capture: assert property (
      (s_r.st == TAP_CAP_IR && tck_rise && !s_r.por_busy && jtag_en_i)
      |=> s_r.ir_sh == IR_CAPT)
      else $error("instruction capture pattern wrong");
   chk_highz_floats: assert property (
      s_r.ir == IR_HIGHZ |=> s_r.pin_oe == '0)
      else $error("pin driven while high impedance selected");
   chk_extest_drive: assert property (
      (extest && !s_r.por_busy) |=> s_r.pin_out == $past(upd_out))
      else $error("external test does not drive update values");
   chk_capture_strobe: assert property (
      s_r.cap_en |-> $past(tck_rise) && $past(s_r.st) == TAP_CAP_DR)
      else $error("capture strobe outside capture state");
   chk_tdo_ir_shift: assert property (
      (tck_fall && s_r.st == TAP_SH_IR && jtag_en_i && !s_r.por_busy)
      |=> s_r.tdo == $past(s_r.ir_sh[0]) && s_r.tdo_oe)
      else $error("instruction shift output wrong");
   chk_jtag_off_gpio: assert property (
      !jtag_en_i |=> s_r.jp_out == $past(user_jtag_out_i) &&
                     s_r.jp_oe == $past(user_jtag_oe_i))
      else $error("test pins not released to user logic");
   chk_fuse_refuses: assert property (
      (isp_rd_req_i && !isp_rd_sig_i && fuse_blown_i)
      |=> isp_rd_refused_o && !isp_rd_ok_o)
      else $error("verify read allowed with fuse blown");
   chk_sig_readable: assert property (
      (isp_rd_req_i && isp_rd_sig_i) |=> isp_rd_ok_o && !isp_rd_refused_o)
      else $error("signature read refused");
   chk_small_hyst: assert property (
      (!HYST_LARGE && !s_r.vdd_s2) |=> s_r.por_busy)
      else $error("supply drop did not restart power-up reset");
   chk_por_output: assert property (
      s_r.por_busy ##1 s_r.por_busy |->
      pin_out_o == OUT_POL && pin_oe_o == '0)
      else $error("outputs not at polarity level during reset");

   cov_extest: cover property (extest && s_r.upd_en);
   cov_id_shift: cover property (s_r.ir == IR_IDCODE && s_r.st == TAP_SH_DR);
   cov_ir_update: cover property (s_r.st == TAP_UPD_IR && tck_rise);
   cov_por_release: cover property ($fell(s_r.por_busy));
endmodule : jtag_boundary_scan_isp_port

// >>> core/jtag_isp_pkg.sv
// Purpose: Shared constants and types for the test and programming port.
// Assumes: 20 MHz core clock; the test clock is sampled, not used as clock.
// Notes: Instruction codes are 4 bits; unknown codes select the bypass bit.
package jtag_isp_pkg;
   localparam int NUM_IO_PINS = 68;
   localparam int NUM_IN_PINS = 4;
   localparam int NUM_MC = 64;
   localparam int IR_W = 4;
   localparam int ID_W = 32;
   localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
   localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
   localparam logic [IR_W-1:0] IR_IDCODE = 4'h2;
   localparam logic [IR_W-1:0] IR_HIGHZ = 4'h3;
   localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
   localparam logic [IR_W-1:0] IR_CAPT = 4'h1;
   // Pin positions inside the four-pin test port group.
   localparam int JP_TCK = 0;
   localparam int JP_TMS = 1;
   localparam int JP_TDI = 2;
   localparam int JP_TDO = 3;
   // Capture stage positions inside a pin cell; scan runs from 2 to 0.
   localparam int CB_IN = 2;
   localparam int CB_OUT = 1;
   localparam int CB_OE = 0;
   localparam int UB_OUT = 1;
   localparam int UB_OE = 0;
   localparam int CLK_PERIOD_NS = 50;
   localparam int POR_TD_NS = 1000;
   localparam int POR_TD_CYC =
      (POR_TD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HYST_DROP_NS = 500;
   localparam int HYST_DROP_CYC =
      (HYST_DROP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   typedef enum logic [3:0] {
      TAP_TLR = 4'h0,
      TAP_RTI = 4'h1,
      TAP_SEL_DR = 4'h3,
      TAP_CAP_DR = 4'h2,
      TAP_SH_DR = 4'h6,
      TAP_EX1_DR = 4'h7,
      TAP_UPD_DR = 4'h5,
      TAP_PAU_DR = 4'h4,
      TAP_EX2_DR = 4'hC,
      TAP_SEL_IR = 4'hD,
      TAP_CAP_IR = 4'hF,
      TAP_SH_IR = 4'hE,
      TAP_EX1_IR = 4'hA,
      TAP_PAU_IR = 4'hB,
      TAP_EX2_IR = 4'h9,
      TAP_UPD_IR = 4'h8
   } tap_state_e;
endpackage : jtag_isp_pkg

// >>> dv/jtag_boundary_scan_isp_port_bench.sv
// Purpose: Self-checking bench for the test access and programming port.
// Assumes: Small chain of 4 I/O, 2 inputs and 4 macrocells; short reset count.
// Notes: Chain position is 3*cell+stage (in, out, oe), macrocells last;
//    the first bit shifted in ends nearest TDO.
`timescale 1ns/1ps
module jtag_boundary_scan_isp_port_bench
   import jtag_isp_pkg::*;
;
   localparam int NP = 6;
   localparam int NM = 4;
   localparam int CL = 3 * NP + NM;
   localparam int TDC = 3;
   localparam logic [NP-1:0] POL = 6'h2D;
   // Identification value is arbitrary.
   localparam logic [31:0] ID_VAL = 32'h0F0F_1235;
   logic core_clk_i, sys_rst_i, jtag_en_i, vdd_ok_i, fuse_blown_i;
   logic isp_rd_req_i, isp_rd_sig_i, isp_rd_ok_o, isp_rd_refused_o;
   logic por_busy_o, tck, tms, tdi, hv, flt_r;
   logic [3:0] jtag_pin_i, user_jtag_out_i, user_jtag_oe_i, lvl;
   logic [3:0] jtag_pin_o, jtag_pin_oe_o, user_jtag_in_o;
   logic [NP-1:0] pin_in_i, core_out_i, core_oe_i;
   logic [NP-1:0] pin_out_o, pin_oe_o, core_in_o;
   logic [NM-1:0] mc_out_i;
   logic [31:0] hres, d, se;
   logic [1:0] ie;
   logic [1:0] isp_q[$];
   logic [31:0] scan_q[$];
   int bad_count, n_checks, cyc, n;

   // The TDO wire floats to a changing level whenever nobody drives it.
   assign lvl = {flt_r, tdi, tms, tck};
   assign jtag_pin_i = (jtag_pin_oe_o & jtag_pin_o) | (~jtag_pin_oe_o & lvl);

   jtag_boundary_scan_isp_port #(.NIO(4), .NIN(2), .NMC(NM), .OUT_POL(POL),
      .HYST_LARGE(1'b0), .TD_CYC(TDC), .DROP_CYC(2), .IDCODE(ID_VAL)) dut (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .jtag_en_i(jtag_en_i),
      .vdd_ok_i(vdd_ok_i), .fuse_blown_i(fuse_blown_i),
      .isp_rd_req_i(isp_rd_req_i), .isp_rd_sig_i(isp_rd_sig_i),
      .jtag_pin_i(jtag_pin_i), .user_jtag_out_i(user_jtag_out_i),
      .user_jtag_oe_i(user_jtag_oe_i), .pin_in_i(pin_in_i),
      .core_out_i(core_out_i), .core_oe_i(core_oe_i), .mc_out_i(mc_out_i),
      .jtag_pin_o(jtag_pin_o), .jtag_pin_oe_o(jtag_pin_oe_o),
      .user_jtag_in_o(user_jtag_in_o), .pin_out_o(pin_out_o),
      .pin_oe_o(pin_oe_o), .core_in_o(core_in_o), .isp_rd_ok_o(isp_rd_ok_o),
      .isp_rd_refused_o(isp_rd_refused_o), .por_busy_o(por_busy_o));

   jtag_host_model host (.tdo_i(jtag_pin_i[3]), .tck_o(tck), .tms_o(tms),
      .tdi_o(tdi), .res_valid_o(hv), .res_o(hres));

   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t mismatch seen %h exp %h", $time, seen, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic wait_busy(input logic lv, output int k);
      k = 0;
      while (por_busy_o !== lv && k < 100) begin
         @(posedge core_clk_i);
         k++;
      end
   endtask : wait_busy

   function automatic logic [31:0] sample_exp();
      logic [31:0] v;
      v = '0;
      for (int c = 0; c < NP; c++) begin
         v[CL-1-3*c] = pin_in_i[c];
         v[CL-2-3*c] = core_out_i[c];
         v[CL-3-3*c] = core_oe_i[c];
      end
      for (int m = 0; m < NM; m++) begin
         v[CL-1-3*NP-m] = mc_out_i[m];
      end
      return v;
   endfunction : sample_exp

   task automatic chk_pins(input logic [31:0] din);
      logic [NP-1:0] po, pe;
      for (int c = 0; c < NP; c++) begin
         po[c] = din[CL-2-3*c];
         pe[c] = (c < 4) ? din[CL-3-3*c] : 1'b0;
      end
      chk(pin_out_o, po);
      chk(pin_oe_o, pe);
   endtask : chk_pins

   task automatic scan_w(input logic ir, input int nb, input logic [31:0] din,
         input logic [31:0] ex, input logic rep);
      if (rep) begin
         scan_q.push_back(ex);
      end
      host.scan(ir, nb, din, rep);
      @(posedge core_clk_i);
   endtask : scan_w

   task automatic isp_req(input logic sig);
      isp_rd_req_i <= 1'b1;
      isp_rd_sig_i <= sig;
      isp_q.push_back((fuse_blown_i && !sig) ? 2'b01 : 2'b10);
      @(posedge core_clk_i);
   endtask : isp_req

   always @(posedge core_clk_i) begin
      flt_r <= ~flt_r;
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         $display("[ERR] %0t run did not finish in time", $time);
         finish_test();
      end
      if (isp_rd_ok_o === 1'b1 || isp_rd_refused_o === 1'b1) begin
         ie = (isp_q.size() > 0) ? isp_q.pop_front() : 2'b11;
         chk({isp_rd_ok_o, isp_rd_refused_o}, ie);
      end
   end

   always @(posedge hv) begin
      se = (scan_q.size() > 0) ? scan_q.pop_front() : ~hres;
      chk(hres, se);
   end

   initial begin
      flt_r = 1'b0;
      cyc = 0;
      bad_count = 0;
      n_checks = 0;
      void'($urandom(32'h1414));
      sys_rst_i = 1'b1;
      jtag_en_i = 1'b0;
      vdd_ok_i = 1'b1;
      fuse_blown_i = 1'b0;
      isp_rd_req_i = 1'b0;
      isp_rd_sig_i = 1'b0;
      user_jtag_out_i = 4'($urandom());
      user_jtag_oe_i = 4'($urandom());
      pin_in_i = NP'($urandom());
      core_out_i = NP'($urandom());
      core_oe_i = NP'($urandom());
      mc_out_i = NM'($urandom());
      repeat (4) @(posedge core_clk_i);
      chk(pin_out_o, POL);
      chk(pin_oe_o, 0);
      chk(por_busy_o, 1);
      sys_rst_i <= 1'b0;
      wait_busy(1'b0, n);
      chk(n >= TDC && n < 100, 1);
      repeat (6) @(posedge core_clk_i);
      chk(jtag_pin_o, user_jtag_out_i);
      chk(jtag_pin_oe_o, user_jtag_oe_i);
      chk(user_jtag_in_o[2:0], jtag_pin_i[2:0]);
      chk(core_in_o, pin_in_i);
      jtag_en_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      chk(jtag_pin_oe_o, 0);
      host.to_idle();
      @(posedge core_clk_i);
      scan_w(1'b0, 32, $urandom(), ID_VAL, 1'b1);
      scan_w(1'b1, 4, IR_SAMPLE, 32'h0000_0001, 1'b1);
      d = $urandom();
      scan_w(1'b0, CL, d, sample_exp(), 1'b1);
      scan_w(1'b1, 4, IR_EXTEST, 32'h0000_0001, 1'b1);
      repeat (6) @(posedge core_clk_i);
      chk_pins(d);
      d = $urandom();
      scan_w(1'b0, CL, d, 0, 1'b0);
      repeat (6) @(posedge core_clk_i);
      chk_pins(d);
      scan_w(1'b1, 4, IR_HIGHZ, 32'h0000_0001, 1'b1);
      repeat (6) @(posedge core_clk_i);
      chk(pin_oe_o, 0);
      // An undefined code must behave as the one-bit bypass path.
      for (int k = 0; k < 2; k++) begin
         scan_w(1'b1, 4, k ? 4'h7 : IR_BYPASS, 32'h0000_0001, 1'b1);
         d = $urandom();
         scan_w(1'b0, 8, d, {24'h0, d[6:0], 1'b0}, 1'b1);
      end
      scan_w(1'b1, 4, IR_IDCODE, 32'h0000_0001, 1'b1);
      scan_w(1'b0, 32, $urandom(), ID_VAL, 1'b1);
      for (int f = 0; f < 2; f++) begin
         fuse_blown_i <= f[0];
         @(posedge core_clk_i);
         isp_req(1'b0);
         isp_req(1'b1);
         isp_rd_req_i <= 1'b0;
         repeat (3) @(posedge core_clk_i);
      end
      vdd_ok_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      vdd_ok_i <= 1'b1;
      wait_busy(1'b1, n);
      chk(n < 8, 1);
      wait_busy(1'b0, n);
      chk(pin_oe_o, 0);
      host.to_idle();
      @(posedge core_clk_i);
      scan_w(1'b0, 32, $urandom(), ID_VAL, 1'b1);
      repeat (20) @(posedge core_clk_i);
      chk(scan_q.size() + isp_q.size(), 0);
      finish_test();
   end
endmodule : jtag_boundary_scan_isp_port_bench

// >>> dv/jtag_host_model.sv
// Purpose: Behavioural test host that drives the four-wire test port.
// Assumes: 400 ns test clock period; the test clock idles low between frames.
// Notes: TDO is read late in the high phase, well after it has settled.
`timescale 1ns/1ps
module jtag_host_model (
   input wire logic tdo_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   output logic res_valid_o,
   output logic [31:0] res_o
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
      res_valid_o = 1'b0;
      res_o = '0;
   end

   // Lines change only in the low phase, so they are settled before rising.
   task automatic tick(input logic tms, input logic tdi, output logic tdo);
      tms_o = tms;
      tdi_o = tdi;
      #200;
      tck_o = 1'b1;
      #195;
      tdo = tdo_i;
      #5;
      tck_o = 1'b0;
   endtask : tick

   // Five ticks with mode select high reach reset from any state.
   task automatic to_idle();
      logic b;
      #17;
      repeat (5) tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
   endtask : to_idle

   // Scans n bits (at most 32) LSB first from idle and returns to idle.
   task automatic scan(input logic is_ir, input int n,
         input logic [31:0] din, input logic rep);
      logic [31:0] dout;
      logic b;
      dout = '0;
      #17;
      tick(1'b1, 1'b0, b);
      if (is_ir) begin
         tick(1'b1, 1'b0, b);
      end
      tick(1'b0, 1'b0, b);
      tick(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], b);
         dout[i] = b;
      end
      tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
      // Between frames the data line carries no stale copy of the last bit.
      tdi_o = ~tdi_o;
      if (rep) begin
         res_o = dout;
         res_valid_o = 1'b1;
         #50;
         res_valid_o = 1'b0;
      end
   endtask : scan
endmodule : jtag_host_model
